// ### rilo_defs.svh
`ifndef RILO_DEFS_SVH
`define RILO_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RILO_OFF_INH_LINK   12'h000
`define RILO_OFF_LOCK_LINK  12'h004
`define RILO_OFF_STATUS     12'h008
// ----------------------------------------
// field positions, widths, reset values and response codes
// ----------------------------------------
`define RILO_INH_AUX        0
`define RILO_INH_OVR        1
`define RILO_INH_Z1         2
`define RILO_INH_NEG        3
`define RILO_INH_MULTI      4
`define RILO_INH_W          5
`define RILO_LOCK_Z2        0
`define RILO_LOCK_Z3        1
`define RILO_LOCK_TOC       2
`define RILO_LOCK_EXT3P     3
`define RILO_LOCK_W         4
`define RILO_INH_RST        5'h00
`define RILO_LOCK_RST       4'h0
`define RILO_RESP_OKAY      2'b00
`define RILO_RESP_SLVERR    2'b10
`endif

// ### rilo_pkg.sv
package rilo_pkg;
    typedef enum logic [1:0] {
        RILO_IDLE = 2'b00,
        RILO_RESP = 2'b01
    } rilo_bus_state_t;
endpackage

// ### rilo_sync.sv
`timescale 1ns/100ps
`include "rilo_defs.svh"
// two-flop synchroniser for a group of pin levels
module rilo_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // ----------------------------------------
    // synchroniser chain
    // ----------------------------------------
    // first stage feeds only the second stage
    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

// ### rilo_top.sv
`timescale 1ns/100ps
`include "rilo_defs.svh"
// Contract
// R1: trip with any link-enabled distance or multi-phase source sets inhibit
// R2: transferred-trip input also inhibits on trip, with no enable link
// R3: inhibit stays latched while voltage is lost, releases on its return
// R4: lockout asserts on trip while any link-selected lockout source is on
// R5: zone 2, zone 3, time-overcurrent, external three-pole each have a link
// R6: lockout has no seal-in and ends as soon as trip ends
// R7: external reclosing relay locks out while lockout output is energized
// R8: relay may use inhibit output to block reclose on three-phase faults
// R9: each link is a static bit gating its source into assertion and seal-in; the code gates set only, the seal hold uses no link
module rilo_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // scheme inputs, all from pins
    input  wire logic        trip_active,
    input  wire logic        voltage_lost,
    input  wire logic        aux_zone_pos_seq_distance,
    input  wire logic        overreach_pos_seq_distance,
    input  wire logic        zone_one_pos_seq_distance,
    input  wire logic        neg_seq_distance_direct,
    input  wire logic        multi_phase_two_of_three,
    input  wire logic        transferred_trip_input,
    input  wire logic        zone2_timer_trip,
    input  wire logic        zone3_timer_trip,
    input  wire logic        time_overcurrent_trip,
    input  wire logic        ext_three_pole_trip_input,
    output logic             reclose_inhibit_out,
    output logic             reclose_lockout_out,
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [11:0] pins_raw;
    logic [11:0] pins;

    assign pins_raw = {trip_active, voltage_lost,
                       aux_zone_pos_seq_distance,
                       overreach_pos_seq_distance,
                       zone_one_pos_seq_distance,
                       neg_seq_distance_direct,
                       multi_phase_two_of_three,
                       transferred_trip_input,
                       zone2_timer_trip, zone3_timer_trip,
                       time_overcurrent_trip,
                       ext_three_pole_trip_input};

    rilo_sync #(.W(12)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pins_raw),
        .q       (pins)
    );

    logic       trip_s;
    logic       vlost_s;
    logic [4:0] inh_src;
    logic       tt_s;
    logic [3:0] lock_src;

    // bit order matches the link field positions
    assign trip_s   = pins[11];
    assign vlost_s  = pins[10];
    assign inh_src  = {pins[5], pins[6], pins[7], pins[8], pins[9]};
    assign tt_s     = pins[4];
    assign lock_src = {pins[0], pins[1], pins[2], pins[3]};

    // ----------------------------------------
    // link registers and bus state
    // ----------------------------------------
    logic [`RILO_INH_W-1:0]  inh_link;
    logic [`RILO_LOCK_W-1:0] lock_link;
    logic [`RILO_INH_W-1:0]  next_inh_link;
    logic [`RILO_LOCK_W-1:0] next_lock_link;
    rilo_pkg::rilo_bus_state_t wr_state;
    rilo_pkg::rilo_bus_state_t next_wr_state;
    rilo_pkg::rilo_bus_state_t rd_state;
    rilo_pkg::rilo_bus_state_t next_rd_state;
    logic        aw_got;
    logic        w_got;
    logic        next_aw_got;
    logic        next_w_got;
    logic [11:0] aw_addr;
    logic [11:0] next_aw_addr;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0]  w_strb;
    logic [3:0]  next_w_strb;
    logic [1:0]  next_bresp;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // ----------------------------------------
    // reclose output logic
    // ----------------------------------------
    logic inh_hit;
    logic lock_hit;
    logic inh_seal;
    logic next_inh_seal;
    logic next_inh_out;
    logic next_lock_out;

    // a disabled link drops its source from set; the hold term uses no source or link
    assign inh_hit  = |(inh_src & inh_link) | tt_s; // R1 R2 R9
    assign lock_hit = |(lock_src & lock_link); // R4 R5 R9

    // seal holds only while voltage is lost; a trip still sets it anyway
    always_comb begin
        next_inh_seal = (trip_s & inh_hit) | (inh_seal & vlost_s); // R1 R3
        next_inh_out  = next_inh_seal;
        next_lock_out = trip_s & lock_hit; // R4 R6
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inh_seal            <= 1'b0;
            reclose_inhibit_out <= 1'b0;
            reclose_lockout_out <= 1'b0;
        end else begin
            inh_seal            <= next_inh_seal;
            reclose_inhibit_out <= next_inh_out; // R3 R8
            reclose_lockout_out <= next_lock_out; // R6 R7
        end
    end

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    logic wr_fire;

    assign s_axi_awready = (wr_state == rilo_pkg::RILO_IDLE) && !aw_got;
    assign s_axi_wready  = (wr_state == rilo_pkg::RILO_IDLE) && !w_got;
    assign s_axi_bvalid  = (wr_state == rilo_pkg::RILO_RESP);
    // registered got flags, write state and raw handshake terms only: the next got flags below depend on this
    assign wr_fire       = (aw_got | (s_axi_awvalid & s_axi_awready))
                           && (w_got | (s_axi_wvalid & s_axi_wready))
                           && (wr_state == rilo_pkg::RILO_IDLE);

    // address and data taken in either order, response once both held
    always_comb begin
        next_aw_got    = aw_got | (s_axi_awvalid & s_axi_awready);
        next_w_got     = w_got | (s_axi_wvalid & s_axi_wready);
        next_aw_addr   = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr
                                                         : aw_addr;
        next_w_data    = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data;
        next_w_strb    = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : w_strb;
        next_wr_state  = wr_state;
        next_bresp     = s_axi_bresp;
        next_inh_link  = inh_link;
        next_lock_link = lock_link;
        unique case (wr_state)
            rilo_pkg::RILO_IDLE: begin
                if (wr_fire) begin
                    next_aw_got   = 1'b0;
                    next_w_got    = 1'b0;
                    next_wr_state = rilo_pkg::RILO_RESP;
                    next_bresp    = `RILO_RESP_OKAY;
                    if ({next_aw_addr[11:2], 2'b00}
                        == `RILO_OFF_INH_LINK) begin
                        if (next_w_strb[0]) begin
                            next_inh_link = next_w_data[`RILO_INH_W-1:0];
                        end
                    end else if ({next_aw_addr[11:2], 2'b00}
                                 == `RILO_OFF_LOCK_LINK) begin
                        if (next_w_strb[0]) begin
                            next_lock_link = next_w_data[`RILO_LOCK_W-1:0];
                        end
                    end else if ({next_aw_addr[11:2], 2'b00}
                                 != `RILO_OFF_STATUS) begin
                        next_bresp = `RILO_RESP_SLVERR;
                    end
                end
            end
            rilo_pkg::RILO_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = rilo_pkg::RILO_IDLE;
                end
            end
            default: begin
                next_wr_state = rilo_pkg::RILO_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state    <= rilo_pkg::RILO_IDLE;
            aw_got      <= 1'b0;
            w_got       <= 1'b0;
            aw_addr     <= 12'h000;
            w_data      <= 32'h0000_0000;
            w_strb      <= 4'h0;
            s_axi_bresp <= `RILO_RESP_OKAY;
            inh_link    <= `RILO_INH_RST;
            lock_link   <= `RILO_LOCK_RST;
        end else begin
            wr_state    <= next_wr_state;
            aw_got      <= next_aw_got;
            w_got       <= next_w_got;
            aw_addr     <= next_aw_addr;
            w_data      <= next_w_data;
            w_strb      <= next_w_strb;
            s_axi_bresp <= next_bresp;
            inh_link    <= next_inh_link; // R9
            lock_link   <= next_lock_link; // R9
        end
    end

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    assign s_axi_arready = (rd_state == rilo_pkg::RILO_IDLE);
    assign s_axi_rvalid  = (rd_state == rilo_pkg::RILO_RESP);

    // status word shows live outputs, voltage loss and trip, for field checks
    always_comb begin
        next_rd_state = rd_state;
        next_rdata    = s_axi_rdata;
        next_rresp    = s_axi_rresp;
        unique case (rd_state)
            rilo_pkg::RILO_IDLE: begin
                if (s_axi_arvalid) begin
                    next_rd_state = rilo_pkg::RILO_RESP;
                    next_rresp    = `RILO_RESP_OKAY;
                    next_rdata    = 32'h0000_0000;
                    if ({s_axi_araddr[11:2], 2'b00}
                        == `RILO_OFF_INH_LINK) begin
                        next_rdata[`RILO_INH_W-1:0] = inh_link;
                    end else if ({s_axi_araddr[11:2], 2'b00}
                                 == `RILO_OFF_LOCK_LINK) begin
                        next_rdata[`RILO_LOCK_W-1:0] = lock_link;
                    end else if ({s_axi_araddr[11:2], 2'b00}
                                 == `RILO_OFF_STATUS) begin
                        next_rdata[3:0] = {vlost_s, trip_s,
                                           reclose_lockout_out,
                                           reclose_inhibit_out};
                    end else begin
                        next_rresp = `RILO_RESP_SLVERR;
                    end
                end
            end
            rilo_pkg::RILO_RESP: begin
                if (s_axi_rready) begin
                    next_rd_state = rilo_pkg::RILO_IDLE;
                end
            end
            default: begin
                next_rd_state = rilo_pkg::RILO_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state    <= rilo_pkg::RILO_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RILO_RESP_OKAY;
        end else begin
            rd_state    <= next_rd_state;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule

// ### rilo_checker.sv
`timescale 1ns/100ps
module rilo_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic trip_active,
    input wire logic voltage_lost,
    input wire logic aux_zone_pos_seq_distance,
    input wire logic overreach_pos_seq_distance,
    input wire logic zone_one_pos_seq_distance,
    input wire logic neg_seq_distance_direct,
    input wire logic multi_phase_two_of_three,
    input wire logic transferred_trip_input,
    input wire logic zone2_timer_trip,
    input wire logic zone3_timer_trip,
    input wire logic time_overcurrent_trip,
    input wire logic ext_three_pole_trip_input,
    input wire logic reclose_inhibit_out,
    input wire logic reclose_lockout_out,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ----
    // edges since reset, so the sync flush is never judged
    // ----
    logic [1:0] up;
    logic [1:0] next_up;
    wire any_inh = aux_zone_pos_seq_distance | overreach_pos_seq_distance
        | zone_one_pos_seq_distance | neg_seq_distance_direct
        | multi_phase_two_of_three | transferred_trip_input;
    wire any_lock = zone2_timer_trip | zone3_timer_trip
        | time_overcurrent_trip | ext_three_pole_trip_input;
    always_comb next_up = (up == 2'd3) ? up : up + 2'd1;
    always_ff @(posedge aclk) up <= aresetn ? next_up : 2'd0;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_tt_sets_inh: assert property (up == 2'd3 && $past(trip_active, 3)
        && $past(transferred_trip_input, 3) |-> reclose_inhibit_out)
        else $error("inhibit missed a transferred trip");
    a_inh_seal_hold: assert property (up == 2'd3
        && $past(reclose_inhibit_out) && $past(voltage_lost, 3)
        |-> reclose_inhibit_out) else $error("inhibit seal dropped");
    a_inh_release: assert property (up == 2'd3 && !$past(trip_active, 3)
        && !$past(voltage_lost, 3) |-> !reclose_inhibit_out)
        else $error("inhibit held without loss of voltage");
    a_inh_cause: assert property ($rose(reclose_inhibit_out)
        |-> $past(trip_active, 3) && $past(any_inh, 3))
        else $error("inhibit rose without trip and source");
    a_lock_cause: assert property (reclose_lockout_out
        |-> $past(trip_active, 3) && $past(any_lock, 3))
        else $error("lockout without trip and source");
    a_lock_trip_end: assert property (trip_active ##1 !trip_active[*3]
        |-> ##1 !reclose_lockout_out) else $error("lockout outlived trip");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during response");
    c_lock: cover property ($rose(reclose_lockout_out));
    c_inh: cover property ($rose(reclose_inhibit_out));
    c_seal: cover property (reclose_inhibit_out && !trip_active
        && voltage_lost);
endmodule
bind rilo_top rilo_checker chk_u (.*);

// ### rilo_recloser.sv
`timescale 1ns/100ps
// far-side reclosing relay; permits a reclose only when unblocked
module rilo_recloser (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic lockout_in,
    input  wire logic inhibit_in,
    input  wire logic block_on_inhibit,
    output logic      reclose_allowed
);
    logic next_allowed;
    // inhibit blocks only if the user opted in, accepting lost recloses
    always_comb begin
        next_allowed = !lockout_in
            && !(block_on_inhibit && inhibit_in);
    end
    always_ff @(posedge aclk) begin
        reclose_allowed <= aresetn ? next_allowed : 1'b0;
    end
endmodule

// ### testbench.sv
`timescale 1ns/100ps
`include "rilo_defs.svh"
module testbench;
    logic        aclk, aresetn, blk, allowed, inh_m, reclose_inhibit_out;
    logic        trip_active, voltage_lost, transferred_trip_input;
    logic        aux_zone_pos_seq_distance, overreach_pos_seq_distance;
    logic        zone_one_pos_seq_distance, neg_seq_distance_direct;
    logic        multi_phase_two_of_three, zone2_timer_trip;
    logic        zone3_timer_trip, time_overcurrent_trip;
    logic        ext_three_pole_trip_input, reclose_lockout_out;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr, p, np;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
    logic [3:0]  s_axi_wstrb, ll;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [4:0]  li;
    int          fails, checked, cyc;
    rilo_top dut_u (.*);
    rilo_recloser rcl_u (.aclk, .aresetn, .lockout_in(reclose_lockout_out),
        .inhibit_in(reclose_inhibit_out), .block_on_inhibit(blk),
        .reclose_allowed(allowed));
    assign {ext_three_pole_trip_input, time_overcurrent_trip, zone3_timer_trip,
        zone2_timer_trip, transferred_trip_input, multi_phase_two_of_three,
        neg_seq_distance_direct, zone_one_pos_seq_distance,
        overreach_pos_seq_distance, aux_zone_pos_seq_distance, voltage_lost,
        trip_active} = p;
    // ----
    // clock, hang guard, helpers
    // ----
    initial begin
        aclk = 0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic f_set(logic [11:0] q, logic [4:0] k);
        return q[0] & ((|(q[6:2] & k)) | q[7]);
    endfunction
    function automatic logic f_lock(logic [11:0] q, logic [3:0] k);
        return q[0] & (|(q[11:8] & k));
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checked++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // master holds each channel until its ready was seen high
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
        logic pa, pw, ta, tw, bv;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        pa = 1;
        pw = 1;
        bv = 0;
        while (pa || pw) begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            @(posedge aclk);
            if (pa && ta) s_axi_awvalid <= 0;
            if (pw && tw) s_axi_wvalid <= 0;
            pa = pa & !ta;
            pw = pw & !tw;
        end
        while (!bv) begin
            @(negedge aclk);
            bv = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        logic ta, rv;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        ta = 0;
        rv = 0;
        while (!ta) begin
            @(negedge aclk);
            ta = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 0;
        while (!rv) begin
            @(negedge aclk);
            rv = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 0;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        {aresetn, blk, p, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
        {s_axi_wdata, li, ll, inh_m, fails, checked, cyc} = 0;
        s_axi_wstrb = 4'hf;
        seed = 32'hebf7_d2a8;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 3; i++) begin
            rd(12'(4 * i), d, r);
            chk("reset value", d, 32'h0000_0000);
        end
        rd(12'h00c, d, r);
        chk("unmapped read", {d[29:0], r}, {30'h0, `RILO_RESP_SLVERR});
        wr(12'h010, 32'h0000_001f, r);
        chk("unmapped write", r, `RILO_RESP_SLVERR);
        // low byte strobe off: link must keep its reset value
        s_axi_wstrb <= 4'he;
        wr(`RILO_OFF_INH_LINK, 32'h0000_001f, r);
        s_axi_wstrb <= 4'hf;
        rd(`RILO_OFF_INH_LINK, d, r);
        chk("masked write", d, 32'h0000_0000);
        $display("test registers done");
        for (int i = 0; i < 64; i++) begin
            seed = xs(seed);
            np = (i == 0) ? 12'hf83 : (i == 1) ? 12'h002 : seed[11:0];
            if (i == 2) np = 12'h000;
            if (i % 8 == 3) begin
                li = seed[16:12];
                ll = seed[20:17];
                wr(`RILO_OFF_INH_LINK, {27'h0, li}, r);
                chk("link write", r, `RILO_RESP_OKAY);
                wr(`RILO_OFF_LOCK_LINK, {28'h0, ll}, r);
                inh_m = f_set(p, li) | (inh_m & p[1]);
            end
            @(posedge aclk);
            p <= np;
            blk <= seed[31];
            inh_m = f_set(np, li) | (inh_m & np[1]);
            repeat (5) @(posedge aclk);
            #1;
            chk("lockout", reclose_lockout_out, f_lock(np, ll));
            chk("inhibit", reclose_inhibit_out, inh_m);
            chk("allowed", allowed, !(f_lock(np, ll) | blk & inh_m));
            rd(`RILO_OFF_STATUS, d, r);
            chk("status", d, {28'h0, np[1:0], f_lock(np, ll), inh_m});
        end
        $display("test reclose outputs done");
        results();
    end
endmodule
